/* common/pvl_consts.vh */
// Purpose: Constants for the output-voltage floor and telemetry config bank
// Assumes: Command codes are the register offsets of the command bank
// Notes:   Included by the valley decode and bank design files of this block
`ifndef PVL_CONSTS_VH
`define PVL_CONSTS_VH

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define PVL_CMD_DATE        8'h9d
`define PVL_CMD_FLOOR       8'ha4
`define PVL_CMD_VALLEY      8'hd0
`define PVL_CMD_AVG         8'hd1
`define PVL_CMD_VOUT_READ   8'hd4
`define PVL_CMD_PROTO       8'he3

// ------------------------------------------------------------
// Reset values and field layout
// ------------------------------------------------------------
`define PVL_FLOOR_RST       8'h00
`define PVL_VALLEY_NVM      4'h8
`define PVL_AVG_RST         8'h50
`define PVL_AVG_MASK        8'h73
`define PVL_AVG_PIN_RST     3'h5
`define PVL_AVG_IV_RST      2'h0
`define PVL_DATE_FIXED      8'h01
`define PVL_DATE_RST        8'h00
`define PVL_ZERO8           8'h00
`define PVL_ZERO16          16'h0000

// ------------------------------------------------------------
// Valley current limit table, amperes
// ------------------------------------------------------------
`define PVL_VALLEY_BASE_A   8'h18
`define PVL_VALLEY_STEP_A   8'h03
`define PVL_VALLEY_TOP_CODE 4'hb
`define PVL_VALLEY_66_A     8'h42
`define PVL_VALLEY_69_A     8'h45
`define PVL_VALLEY_MAX_CODE 4'hf

// ------------------------------------------------------------
// Status bit positions
// ------------------------------------------------------------
`define PVL_SB_OTHER_BIT    0
`define PVL_SW_VOUT_BIT     15

// ------------------------------------------------------------
// Readback exponent, two's complement of minus nine
// ------------------------------------------------------------
`define PVL_VOUT_EXP        5'h17

`endif

/* design/pvl_vid_clamp.v */
// Purpose: Clamp a requested VID code to the stored floor
// Assumes: VID codes rise with voltage in both protocol tables
// Notes:   Code zero means output off and is never clamped
`timescale 1ns/1ps
`default_nettype none
module pvl_vid_clamp
(
    // Request and floor
    input  wire [7:0] req_vid,
    input  wire [7:0] floor_vid,
    // Result
    output wire [7:0] out_vid,
    output wire       below
);
    assign below   = (req_vid != 8'h00) && (req_vid < floor_vid);
    assign out_vid = below ? floor_vid : req_vid;
endmodule
`default_nettype wire

/* design/pvl_valley_decode.v */
// Purpose: Decode the valley current limit code into amperes
// Assumes: Codes beyond the linear range follow the table
// Notes:   Purely combinational
`include "pvl_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module pvl_valley_decode
(
    // Code
    input  wire [3:0] code,
    // Limit in amperes
    output reg  [7:0] amps
);
    always @*
    begin
        if (code <= `PVL_VALLEY_TOP_CODE)
            amps = `PVL_VALLEY_BASE_A + ({4'h0, code} * `PVL_VALLEY_STEP_A);
        else if (code == `PVL_VALLEY_MAX_CODE)
            amps = `PVL_VALLEY_69_A;
        else
            amps = `PVL_VALLEY_66_A;
    end
endmodule
`default_nettype wire

/* design/pvl_bank.v */
// Purpose: Floor, valley limit, averaging, date and readback commands
// Assumes: Command port is a decoded write/read strobe pair from the
//          management interface; all inputs synchronous to sys_clk
// Notes:   Floor clamps every path to the voltage target except a request in a floor-write cycle, which gets the old floor
`include "pvl_consts.vh"
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Below-floor request commands the floor instead
// - Floor holds for every command path except a request in the cycle of a floor write
// - Below-floor attempt sets status byte other flag
// - Below-floor attempt sets status word voltage flag
// - Below-floor attempt asserts alert to host
// - Below-floor attempt is warning, no fault response
// - Floor: high byte zero, low byte writable
// - Floor VID uses strap or protocol command
// - Valley code 24A to 57A, 66A, 69A
// - Written valley limit overrides strap; default 08h
// - Bits 6:4 select input power averaging
// - Bits 1:0 select current/voltage averaging
// - Averaging register resets to 50h
// - Readback is unsigned mantissa, exponent minus nine
module pvl_bank
#(
    parameter USE_NVM_VALLEY = 1
)
(
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rstn,
    // Command write port
    input  wire        cmd_wr,
    input  wire [7:0]  cmd_code,
    input  wire [15:0] cmd_wdata,
    // Command read port
    input  wire        cmd_rd,
    output reg  [15:0] cmd_rdata_q,
    output reg         cmd_ack_q,
    // Voltage requests from other commands
    input  wire        vid_req,
    input  wire [7:0]  vid_req_code,
    // Status clearing
    input  wire        clear_faults,
    // Straps and measurements
    input  wire        protocol_strap,
    input  wire [3:0]  current_limit_strap,
    input  wire [15:0] vout_meas,
    // Outputs to the controller
    output reg  [7:0]  vout_target_q,
    output reg         vid_protocol_q,
    output reg  [3:0]  valley_limit_code_q,
    output reg  [7:0]  valley_limit_amps_q,
    output reg  [2:0]  input_power_avg_sel_q,
    output reg  [1:0]  current_voltage_avg_sel_q,
    output reg         status_other_q,
    output reg         status_vout_q,
    output reg         alert_q,
    output reg         fault_resp_q
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg  [7:0] floor_q;
    reg  [7:0] date_writable_byte_q;
    reg  [3:0] valley_q;
    reg        valley_written_q;
    reg  [7:0] avg_q;
    reg        proto_written_q;
    reg        proto_cfg_q;
    reg  [7:0] req_now;
    wire [7:0] clamp_vid;
    wire       below;
    wire [7:0] amps;
    wire [3:0] valley_eff;
    wire       floor_wr;
    wire       any_req;

    assign floor_wr = cmd_wr && (cmd_code == `PVL_CMD_FLOOR);
    assign any_req  = vid_req;

    always @*
    begin
        req_now = vid_req_code;
    end

    // ------------------------------------------------------------
    // Floor clamp on the request path
    // ------------------------------------------------------------
    pvl_vid_clamp u_clamp
    (
        .req_vid   (req_now),
        .floor_vid (floor_q),
        .out_vid   (clamp_vid),
        .below     (below)
    );

    // Effective valley code: written value wins over strap
    assign valley_eff = valley_written_q ? valley_q : current_limit_strap;

    pvl_valley_decode u_valley
    (
        .code (valley_eff),
        .amps (amps)
    );

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            floor_q              <= `PVL_FLOOR_RST;
            date_writable_byte_q <= `PVL_DATE_RST;
            valley_q             <= `PVL_VALLEY_NVM;
            valley_written_q     <= (USE_NVM_VALLEY != 0);
            avg_q                <= `PVL_AVG_RST;
            proto_written_q      <= 1'b0;
            proto_cfg_q          <= 1'b0;
        end
        else if (cmd_wr)
        begin
            case (cmd_code)
                `PVL_CMD_FLOOR:  floor_q <= cmd_wdata[7:0];
                `PVL_CMD_DATE:   date_writable_byte_q <= cmd_wdata[15:8];
                `PVL_CMD_VALLEY:
                begin
                    valley_q         <= cmd_wdata[3:0];
                    valley_written_q <= 1'b1;
                end
                `PVL_CMD_AVG:    avg_q <= cmd_wdata[7:0] & `PVL_AVG_MASK;
                `PVL_CMD_PROTO:
                begin
                    proto_cfg_q     <= cmd_wdata[0];
                    proto_written_q <= 1'b1;
                end
                default:         floor_q <= floor_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Voltage target and floor enforcement
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (!rstn)
            vout_target_q <= `PVL_ZERO8;
        else if (any_req)
            vout_target_q <= clamp_vid;
        else if (floor_wr && (vout_target_q != 8'h00)
                 && (vout_target_q < cmd_wdata[7:0]))
            vout_target_q <= cmd_wdata[7:0];
    end

    // ------------------------------------------------------------
    // Warning flags; a new event wins over a clear
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            status_other_q <= 1'b0;
            status_vout_q  <= 1'b0;
            alert_q        <= 1'b0;
        end
        else if (any_req && below)
        begin
            status_other_q <= 1'b1;
            status_vout_q  <= 1'b1;
            alert_q        <= 1'b1;
        end
        else if (clear_faults)
        begin
            status_other_q <= 1'b0;
            status_vout_q  <= 1'b0;
            alert_q        <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs to the regulator
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            vid_protocol_q            <= 1'b0;
            valley_limit_code_q       <= `PVL_VALLEY_NVM;
            valley_limit_amps_q       <= `PVL_ZERO8;
            input_power_avg_sel_q     <= `PVL_AVG_PIN_RST;
            current_voltage_avg_sel_q <= `PVL_AVG_IV_RST;
            fault_resp_q              <= 1'b0;
        end
        else
        begin
            vid_protocol_q            <= proto_written_q ? proto_cfg_q : protocol_strap;
            valley_limit_code_q       <= valley_eff;
            valley_limit_amps_q       <= amps;
            input_power_avg_sel_q     <= avg_q[6:4];
            current_voltage_avg_sel_q <= avg_q[1:0];
            fault_resp_q              <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            cmd_rdata_q <= `PVL_ZERO16;
            cmd_ack_q   <= 1'b0;
        end
        else
        begin
            cmd_ack_q <= cmd_rd;
            if (cmd_rd)
            begin
                case (cmd_code)
                    `PVL_CMD_FLOOR:     cmd_rdata_q <= {`PVL_ZERO8, floor_q};
                    `PVL_CMD_DATE:      cmd_rdata_q <= {date_writable_byte_q,
                                                       `PVL_DATE_FIXED};
                    `PVL_CMD_VALLEY:    cmd_rdata_q <= {12'h000, valley_eff};
                    `PVL_CMD_AVG:       cmd_rdata_q <= {`PVL_ZERO8, avg_q};
                    `PVL_CMD_VOUT_READ: cmd_rdata_q <= vout_meas;
                    default:            cmd_rdata_q <= `PVL_ZERO16;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* tb/pvl_bank_monitor.sv */
// Purpose: Port checks for pvl_bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module pvl_bank_monitor
(
    // Clock, reset, command port
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        cmd_wr,
    input wire logic        cmd_rd,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata_q,
    input wire logic        cmd_ack_q,
    // Requests, status, telemetry
    input wire logic        vid_req,
    input wire logic [7:0]  vid_req_code,
    input wire logic        clear_faults,
    input wire logic [15:0] vout_meas,
    input wire logic [7:0]  vout_target_q,
    input wire logic [2:0]  input_power_avg_sel_q,
    input wire logic [1:0]  current_voltage_avg_sel_q,
    input wire logic        status_other_q,
    input wire logic        status_vout_q,
    input wire logic        alert_q,
    input wire logic        fault_resp_q
);
    default clocking dcb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    sequence s_req;
        vid_req && vid_req_code != 8'h00;
    endsequence
    sequence s_rd(logic [7:0] c);
        cmd_rd && cmd_code == c;
    endsequence
    property p_clamp;
        s_req |=> vout_target_q >= $past(vid_req_code);
    endproperty
    a_clamp: assert property (p_clamp) else $error("target below request");
    property p_warn;
        $rose(alert_q) |-> status_other_q && status_vout_q && $past(vid_req);
    endproperty
    a_warn: assert property (p_warn) else $error("warning flags not together");
    property p_nofault;
        fault_resp_q == 1'b0;
    endproperty
    a_nofault: assert property (p_nofault) else $error("fault response seen");
    property p_hold;
        alert_q && !clear_faults |=> alert_q && status_other_q && status_vout_q;
    endproperty
    a_hold: assert property (p_hold) else $error("flags dropped early");
    property p_clear;
        clear_faults && !vid_req |=> !alert_q && !status_other_q && !status_vout_q;
    endproperty
    a_clear: assert property (p_clear) else $error("flags not cleared");
    property p_avg_rst;
        $rose(rstn) |-> input_power_avg_sel_q == 3'h5 && current_voltage_avg_sel_q == 2'h0;
    endproperty
    a_avg_rst: assert property (p_avg_rst) else $error("averaging reset value");
    property p_avg_wr;
        cmd_wr && cmd_code == 8'hd1 |=> ##1
            input_power_avg_sel_q == $past(cmd_wdata[6:4], 2) &&
            current_voltage_avg_sel_q == $past(cmd_wdata[1:0], 2);
    endproperty
    a_avg_wr: assert property (p_avg_wr) else $error("averaging write");
    property p_floor_rd;
        s_rd(8'ha4) |=> cmd_ack_q && cmd_rdata_q[15:8] == 8'h00;
    endproperty
    a_floor_rd: assert property (p_floor_rd) else $error("floor high byte");
    property p_vout_rd;
        s_rd(8'hd4) |=> cmd_ack_q && cmd_rdata_q == $past(vout_meas);
    endproperty
    a_vout_rd: assert property (p_vout_rd) else $error("readback value");
endmodule
`default_nettype wire

/* tb/pvl_host_model.sv */
// Purpose: Host side of the command port
// Assumes: Write taken at one edge, read answered one cycle later
// Notes:   Idle write data is inverted so stale values are not trusted
`timescale 1ns/1ps
`default_nettype none
module pvl_host_model
(
    // Clock and answer
    input  wire logic        sys_clk,
    input  wire logic [15:0] cmd_rdata_q,
    input  wire logic        cmd_ack_q,
    // Requests
    output var  logic        cmd_wr,
    output var  logic        cmd_rd,
    output var  logic [7:0]  cmd_code,
    output var  logic [15:0] cmd_wdata
);
    initial
    begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge sys_clk);
        cmd_wr = 1'b1;
        cmd_code = c;
        cmd_wdata = d;
        @(negedge sys_clk);
        cmd_wr = 1'b0;
        cmd_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        @(negedge sys_clk);
        cmd_rd = 1'b1;
        cmd_code = c;
        @(negedge sys_clk);
        cmd_rd = 1'b0;
        d = cmd_ack_q ? cmd_rdata_q : 16'hdead;
    endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for pvl_bank
// Assumes: Inputs change on the falling edge
// Notes:   Commands go through pvl_host_model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cmd_wr, cmd_rd, cmd_ack_q, vid_protocol_q, fault_resp_q;
    logic        status_other_q, status_vout_q, alert_q;
    logic [7:0]  cmd_code, vout_target_q, valley_limit_amps_q;
    logic [15:0] cmd_wdata, cmd_rdata_q, rd_v;
    logic        vid_req = 1'b0, clear_faults = 1'b0, protocol_strap = 1'b0;
    logic [7:0]  vid_req_code = 8'h00;
    logic [3:0]  current_limit_strap = 4'h3, valley_limit_code_q;
    logic [15:0] vout_meas = 16'h0000;
    logic [2:0]  input_power_avg_sel_q;
    logic [1:0]  current_voltage_avg_sel_q;
    int          fails = 0, check_count = 0;
    always #20 sys_clk = ~sys_clk;
    pvl_bank #(.USE_NVM_VALLEY(1)) u_pvl_bank (.sys_clk, .rstn, .cmd_wr, .cmd_code,
        .cmd_wdata, .cmd_rd, .cmd_rdata_q, .cmd_ack_q, .vid_req, .vid_req_code,
        .clear_faults, .protocol_strap, .current_limit_strap, .vout_meas,
        .vout_target_q, .vid_protocol_q, .valley_limit_code_q, .valley_limit_amps_q,
        .input_power_avg_sel_q, .current_voltage_avg_sel_q, .status_other_q,
        .status_vout_q, .alert_q, .fault_resp_q);
    pvl_host_model u_pvl_host_model (.sys_clk, .cmd_rdata_q, .cmd_ack_q, .cmd_wr,
        .cmd_rd, .cmd_code, .cmd_wdata);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
        u_pvl_host_model.rd(c, rd_v);
        chk(rd_v, exp);
    endtask
    task automatic pulse(input bit clr, input logic [7:0] c);
        @(negedge sys_clk);
        clear_faults = clr;
        vid_req = !clr;
        vid_req_code = c;
        @(negedge sys_clk);
        {clear_faults, vid_req} = 2'b00;
        vid_req_code = ~c;
    endtask
    task automatic t_reset;
        chk(input_power_avg_sel_q, 16'h0005);
        rdchk(8'hd1, 16'h0050);
        rdchk(8'ha4, 16'h0000);
        rdchk(8'hd0, 16'h0008);
        chk(valley_limit_code_q, 16'h0008);
        rdchk(8'h9d, 16'h0001);
        rdchk(8'h55, 16'h0000);
    endtask
    task automatic t_floor;
        u_pvl_host_model.wr(8'ha4, 16'hff20);
        rdchk(8'ha4, 16'h0020);
        pulse(1'b0, 8'h10);
        chk(vout_target_q, 16'h0020);
        chk({status_other_q, status_vout_q, alert_q, fault_resp_q}, 16'h000e);
        pulse(1'b0, 8'h30);
        chk({vout_target_q, alert_q}, {7'h00, 8'h30, 1'b1});
        protocol_strap = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(vid_protocol_q, 16'h0001);
        protocol_strap = 1'b0;
        @(negedge sys_clk);
        chk(vid_protocol_q, 16'h0000);
        u_pvl_host_model.wr(8'he3, 16'h0001);
        @(negedge sys_clk);
        chk(vid_protocol_q, 16'h0001);
        pulse(1'b0, 8'h18);
        chk(vout_target_q, 16'h0020);
        pulse(1'b1, 8'h00);
        chk({status_other_q, status_vout_q, alert_q}, 16'h0000);
        u_pvl_host_model.wr(8'ha4, 16'h0040);
        chk({vout_target_q, alert_q}, 16'h0080);
    endtask
    task automatic t_valley;
        int          i;
        logic [15:0] e;
        for (i = 0; i < 16; i++)
        begin
            u_pvl_host_model.wr(8'hd0, {12'hfff, i[3:0]});
            e = (i < 12) ? 16'(24 + 3 * i) : ((i == 15) ? 16'd69 : 16'd66);
            @(negedge sys_clk);
            chk(valley_limit_code_q, i[3:0]);
            chk(valley_limit_amps_q, e);
        end
        rdchk(8'hd0, 16'h000f);
    endtask
    task automatic t_avg;
        int i;
        for (i = 0; i < 8; i++)
        begin
            u_pvl_host_model.wr(8'hd1, {8'hff, 1'b1, i[2:0], 2'b11, i[1:0]});
            @(negedge sys_clk);
            chk({input_power_avg_sel_q, current_voltage_avg_sel_q}, i[2:0] * 4 + i[1:0]);
            rdchk(8'hd1, {9'h000, i[2:0], 2'b00, i[1:0]});
        end
    endtask
    task automatic t_vout;
        @(negedge sys_clk);
        vout_meas = 16'hbeef;
        rdchk(8'hd4, 16'hbeef);
    endtask
    task automatic complete_run;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #40000;
        fails++;
        complete_run;
    end
    initial
    begin
        repeat (6) @(negedge sys_clk);
        rstn = 1'b1;
        t_reset;
        t_floor;
        t_valley;
        t_avg;
        t_vout;
        complete_run;
    end
endmodule
bind pvl_bank pvl_bank_monitor u_pvl_bank_monitor (.sys_clk, .rstn, .cmd_wr, .cmd_rd,
    .cmd_code, .cmd_wdata, .cmd_rdata_q, .cmd_ack_q, .vid_req, .vid_req_code,
    .clear_faults, .vout_meas, .vout_target_q, .input_power_avg_sel_q,
    .current_voltage_avg_sel_q, .status_other_q, .status_vout_q, .alert_q, .fault_resp_q);
`default_nettype wire
